// ==== rtl/tpb_timer.sv ====
// tpb_timer: five-channel 16-bit timer with phase counting, buffering, PWM output control and requests
`timescale 1ns/1ps
`default_nettype none
// How it works
// - phase mode counts every rising and falling edge of both quadrature inputs
// - phase mode exists on channel two only and ignores prescaler settings
// - clear select, capture/compare, enables, flags, compare registers still work in phase mode
// - buffer registers exist only on channels three and four
// - buffered output compare loads buffer into compare register at match
// - buffered capture moves old compare register into buffer as counter is captured
// - complementary mode transfers all buffers but channel three buffer A at period match and channel four underflow
// - reset-synchronized mode transfers all buffers but channel three buffer A at channel three compare A
// - cleared master enable hands the pin back to port data and direction
// - with trigger disable 0 in PWM modes, channel one capture A clears enables
// - level select bits invert PWM output polarity
// - compare match fires on the timer clock leaving the matching count
// - capture sets its flag and loads the counter in the same cycle
// - wrap flag sets on all-ones to zero and zero to all-ones
// - a flag clears only by reading it as one then writing zero
// - fifteen requests, each flag AND its enable
// - reset priority channel zero A down to channel four wrap, regroupable by priority registers
// - complementary mode sets channel three flag A only counting up, channel four wrap only on underflow
module tpb_timer
  import tpb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [tpb_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tpb_pkg::CNT_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [tpb_pkg::CNT_W-1:0] regRdata,
  // encoder and capture pins
  input wire logic quad_input_a,
  input wire logic quad_input_b,
  input wire logic [tpb_pkg::NUM_CH-1:0] captureInA,
  input wire logic [tpb_pkg::NUM_CH-1:0] captureInB,
  // port fallback for channel three/four pins
  input wire logic [5:0] portData,
  input wire logic [5:0] portDir,
  // waveform pins and compare toggles
  output logic [5:0] pinOut,
  output logic [5:0] pinOe,
  output logic [tpb_pkg::NUM_CH-1:0] compareOutA,
  output logic [tpb_pkg::NUM_CH-1:0] compareOutB,
  // interrupt requests
  output logic [tpb_pkg::NUM_IRQ-1:0] irqRequest,
  output logic [3:0] irqVector
);
  import tpb_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0][CNT_W-1:0] cnt;
    logic [NUM_CH-1:0][CNT_W-1:0] gra;
    logic [NUM_CH-1:0][CNT_W-1:0] grb;
    logic [1:0][CNT_W-1:0] bufA;
    logic [1:0][CNT_W-1:0] bufB;
    logic [NUM_CH-1:0][5:0] ctrl;
    logic [NUM_CH-1:0][2:0] ier;
    logic [NUM_CH-1:0][2:0] flag;
    logic [NUM_CH-1:0][2:0] armed;
    logic [NUM_CH-1:0] start;
    logic [6:0] mode;
    logic [5:0] output_master_enable_reg;
    logic [2:0] output_control_reg;
    logic [2:0] prioA;
    logic [1:0] prioB;
    logic [2:0] pre;
    logic qaPrev;
    logic qbPrev;
    logic [NUM_CH-1:0] capAPrev;
    logic [NUM_CH-1:0] capBPrev;
    logic downward;
    logic [NUM_CH-1:0] outA;
    logic [NUM_CH-1:0] outB;
    logic [2:0] pwm;
    logic [CNT_W-1:0] rdata;
    logic [5:0] pinOut;
    logic [5:0] pinOe;
    logic [NUM_IRQ-1:0] irq;
    logic [3:0] vec;
  } tpb_state_t;

  tpb_state_t s;
  tpb_state_t n;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // timer clock enable from the shared prescaler: /1, /2, /4, /8
  function automatic logic prescaleHit(input logic [1:0] sel, input logic [2:0] pre);
    case (sel)
      2'h0: prescaleHit = 1'b1;
      2'h1: prescaleHit = pre[0];
      2'h2: prescaleHit = &pre[1:0];
      default: prescaleHit = &pre;
    endcase
  endfunction : prescaleHit

  // highest pending request: raised-priority channels first, each group in channel order
  function automatic logic [3:0] pickVector(input logic [NUM_IRQ-1:0] req, input logic [4:0] hiCh);
    logic found;
    pickVector = NO_VECTOR;
    found = 1'b0;
    for (int g = 1; g >= 0; g--) begin
      for (int k = 0; k < NUM_IRQ; k++) begin
        if (!found && req[k] && (hiCh[k / 3] == g[0])) begin
          pickVector = 4'(k);
          found = 1'b1;
        end
      end
    end
  endfunction : pickVector

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [NUM_CH-1:0] tick;
  logic [NUM_CH-1:0] countUp;
  logic [NUM_CH-1:0] matchA;
  logic [NUM_CH-1:0] matchB;
  logic [NUM_CH-1:0] capEvA;
  logic [NUM_CH-1:0] capEvB;
  logic phUp;
  logic phDn;
  logic cmpMode;
  logic rsMode;
  logic pwmMode;
  logic xfer;
  logic [5:0] timerLevel;
  logic [5:0] timerOwns;
  logic [3:0] chSel;
  logic [3:0] regSel;

  always_comb begin
    n = s;
    chSel = regAddr[7:4];
    regSel = regAddr[3:0];
    cmpMode = s.mode[MODE_COMPLEMENTARY];
    rsMode = s.mode[MODE_RESET_SYNC];
    pwmMode = cmpMode | rsMode;
    xfer = 1'b0;
    n.pre = s.pre + 3'h1;
    n.qaPrev = quad_input_a;
    n.qbPrev = quad_input_b;
    n.capAPrev = captureInA;
    n.capBPrev = captureInB;
    // quadrature edge decoding, both edges of both inputs
    phUp = (quad_input_b & ~s.qbPrev & ~quad_input_a) | (quad_input_a & ~s.qaPrev & quad_input_b) |
           (~quad_input_b & s.qbPrev & quad_input_a) | (~quad_input_a & s.qaPrev & ~quad_input_b);
    phDn = (quad_input_b & ~s.qbPrev & quad_input_a) | (quad_input_a & ~s.qaPrev & ~quad_input_b) |
           (~quad_input_b & s.qbPrev & ~quad_input_a) | (~quad_input_a & s.qaPrev & quad_input_b);

    for (int i = 0; i < NUM_CH; i++) begin
      tick[i] = s.start[i] & prescaleHit(s.ctrl[i][CTRL_PSC_LSB +: 2], s.pre);
      countUp[i] = 1'b1;
      capEvA[i] = s.ctrl[i][CTRL_CAP_A] & captureInA[i] & ~s.capAPrev[i];
      capEvB[i] = s.ctrl[i][CTRL_CAP_B] & captureInB[i] & ~s.capBPrev[i];
    end
    if (s.mode[MODE_PHASE]) begin
      tick[2] = s.start[2] & (phUp | phDn);
      countUp[2] = phUp;
    end
    if (cmpMode) begin
      tick[4] = tick[3];
      countUp[3] = ~s.downward;
      countUp[4] = ~s.downward;
    end
    // match is seen on the timer clock that moves the counter off the matching value
    for (int i = 0; i < NUM_CH; i++) begin
      matchA[i] = tick[i] & ~s.ctrl[i][CTRL_CAP_A] & (s.cnt[i] == s.gra[i]);
      matchB[i] = tick[i] & ~s.ctrl[i][CTRL_CAP_B] & (s.cnt[i] == s.grb[i]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes first, so hardware events in the same cycle override them
    if (regWrite) begin
      if (chSel < 4'(NUM_CH)) begin
        case (regSel)
          REG_CTRL: n.ctrl[chSel] = regWdata[5:0];
          REG_IRQ_ENABLE: n.ier[chSel] = regWdata[2:0];
          REG_STATUS: begin
            for (int k = 0; k < 3; k++) begin
              if (!regWdata[k] && s.armed[chSel][k]) begin
                n.flag[chSel][k] = 1'b0;
              end
            end
            n.armed[chSel] = 3'h0;
          end
          REG_COUNTER: n.cnt[chSel] = regWdata;
          REG_COMPARE_A: n.gra[chSel] = regWdata;
          REG_COMPARE_B: n.grb[chSel] = regWdata;
          REG_BUFFER_A: begin
            if (chSel >= 4'(BUF_CH_FIRST)) begin
              n.bufA[chSel[0] ^ 1'b1] = regWdata;
            end
          end
          REG_BUFFER_B: begin
            if (chSel >= 4'(BUF_CH_FIRST)) begin
              n.bufB[chSel[0] ^ 1'b1] = regWdata;
            end
          end
          default: ;
        endcase
      end else begin
        case (regAddr)
          ADDR_START: n.start = regWdata[NUM_CH-1:0];
          ADDR_MODE: n.mode = regWdata[6:0];
          ADDR_OUT_ENABLE: n.output_master_enable_reg = regWdata[5:0];
          ADDR_OUT_CONTROL: n.output_control_reg = regWdata[2:0];
          ADDR_PRIO_A: n.prioA = regWdata[2:0];
          ADDR_PRIO_B: n.prioB = regWdata[1:0];
          default: ;
        endcase
      end
    end

    // read data, valid the cycle after the strobe; a read of a set flag arms its clear
    n.rdata = '0;
    if (regRead) begin
      if (chSel < 4'(NUM_CH)) begin
        case (regSel)
          REG_CTRL: n.rdata = {10'h000, s.ctrl[chSel]};
          REG_IRQ_ENABLE: n.rdata = {13'h0000, s.ier[chSel]};
          REG_STATUS: begin
            n.rdata = {13'h0000, s.flag[chSel]};
            n.armed[chSel] = s.armed[chSel] | s.flag[chSel];
          end
          REG_COUNTER: n.rdata = s.cnt[chSel];
          REG_COMPARE_A: n.rdata = s.gra[chSel];
          REG_COMPARE_B: n.rdata = s.grb[chSel];
          REG_BUFFER_A: n.rdata = (chSel >= 4'(BUF_CH_FIRST)) ? s.bufA[chSel[0] ^ 1'b1] : '0;
          REG_BUFFER_B: n.rdata = (chSel >= 4'(BUF_CH_FIRST)) ? s.bufB[chSel[0] ^ 1'b1] : '0;
          default: n.rdata = '0;
        endcase
      end else begin
        case (regAddr)
          ADDR_START: n.rdata = {11'h000, s.start};
          ADDR_MODE: n.rdata = {9'h000, s.mode};
          ADDR_OUT_ENABLE: n.rdata = {10'h000, s.output_master_enable_reg};
          ADDR_OUT_CONTROL: n.rdata = {13'h0000, s.output_control_reg};
          ADDR_PRIO_A: n.rdata = {13'h0000, s.prioA};
          ADDR_PRIO_B: n.rdata = {14'h0000, s.prioB};
          default: n.rdata = '0;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel counting, compare, capture and flags
    for (int i = 0; i < NUM_CH; i++) begin
      if (tick[i]) begin
        if ((matchA[i] && s.ctrl[i][CTRL_CLR_LSB +: 2] == CLR_BY_A) ||
            (matchB[i] && s.ctrl[i][CTRL_CLR_LSB +: 2] == CLR_BY_B)) begin
          n.cnt[i] = '0;
        end else begin
          n.cnt[i] = countUp[i] ? s.cnt[i] + 16'h0001 : s.cnt[i] - 16'h0001;
          if ((countUp[i] && s.cnt[i] == ALL_ONES) || (!countUp[i] && s.cnt[i] == '0)) begin
            if (!(cmpMode && i == 3)) begin
              n.flag[i][FLAG_WRAP] = 1'b1;
            end
          end
        end
      end
      if (matchA[i] && !(cmpMode && i == 3 && s.downward)) begin
        n.flag[i][FLAG_A] = 1'b1;
        n.outA[i] = ~s.outA[i];
      end
      if (matchB[i]) begin
        n.flag[i][FLAG_B] = 1'b1;
        n.outB[i] = ~s.outB[i];
      end
      // capture overrides a register write in the same cycle
      if (capEvA[i]) begin
        n.gra[i] = s.cnt[i];
        n.flag[i][FLAG_A] = 1'b1;
        if (s.ctrl[i][CTRL_CLR_LSB +: 2] == CLR_BY_A) begin
          n.cnt[i] = '0;
        end
      end
      if (capEvB[i]) begin
        n.grb[i] = s.cnt[i];
        n.flag[i][FLAG_B] = 1'b1;
        if (s.ctrl[i][CTRL_CLR_LSB +: 2] == CLR_BY_B) begin
          n.cnt[i] = '0;
        end
      end
    end

    // buffering in normal operation, channels three and four only
    for (int b = 0; b < 2; b++) begin
      if (!pwmMode && s.mode[MODE_BUF_LSB + 2 * b]) begin
        if (matchA[BUF_CH_FIRST + b]) begin
          n.gra[BUF_CH_FIRST + b] = s.bufA[b];
        end
        if (capEvA[BUF_CH_FIRST + b]) begin
          n.bufA[b] = s.gra[BUF_CH_FIRST + b];
        end
      end
      if (!pwmMode && s.mode[MODE_BUF_LSB + 2 * b + 1]) begin
        if (matchB[BUF_CH_FIRST + b]) begin
          n.grb[BUF_CH_FIRST + b] = s.bufB[b];
        end
        if (capEvB[BUF_CH_FIRST + b]) begin
          n.bufB[b] = s.grb[BUF_CH_FIRST + b];
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // three-phase PWM modes; the reversal steps straight back rather than overshooting
    if (cmpMode && tick[3]) begin
      if (!s.downward && s.cnt[3] == s.gra[3]) begin
        n.downward = 1'b1;
        n.cnt[3] = s.cnt[3] - 16'h0001;
        n.cnt[4] = s.cnt[4] - 16'h0001;
        xfer = 1'b1;
      end else if (s.downward && s.cnt[4] == '0) begin
        n.downward = 1'b0;
        n.cnt[3] = s.cnt[3] + 16'h0001;
        n.cnt[4] = s.cnt[4] + 16'h0001;
        n.flag[4][FLAG_WRAP] = 1'b1;
        xfer = 1'b1;
      end
      if (s.cnt[3] == s.grb[3]) begin
        n.pwm[0] = ~s.pwm[0];
      end
      if (s.cnt[4] == s.gra[4]) begin
        n.pwm[1] = ~s.pwm[1];
      end
      if (s.cnt[4] == s.grb[4]) begin
        n.pwm[2] = ~s.pwm[2];
      end
    end else if (rsMode && tick[3]) begin
      if (s.cnt[3] == s.gra[3]) begin
        n.cnt[3] = '0;
        n.pwm = 3'h0;
        xfer = 1'b1;
      end else begin
        n.cnt[3] = s.cnt[3] + 16'h0001;
        if (s.cnt[3] == s.grb[3]) begin
          n.pwm[0] = 1'b1;
        end
        if (s.cnt[3] == s.gra[4]) begin
          n.pwm[1] = 1'b1;
        end
        if (s.cnt[3] == s.grb[4]) begin
          n.pwm[2] = 1'b1;
        end
      end
    end
    if (!cmpMode) begin
      n.downward = 1'b0;
    end
    if (xfer) begin
      for (int b = 0; b < 2; b++) begin
        if (s.mode[MODE_BUF_LSB + 2 * b] && !(b == 0)) begin
          n.gra[BUF_CH_FIRST + b] = s.bufA[b];
        end
        if (s.mode[MODE_BUF_LSB + 2 * b + 1]) begin
          n.grb[BUF_CH_FIRST + b] = s.bufB[b];
        end
      end
    end

    // external shutdown by channel one capture A
    if (pwmMode && !s.output_control_reg[OC_EXT_TRIG_DISABLE] && capEvA[1]) begin
      n.output_master_enable_reg = 6'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins: timer levels, polarity and master enable
    if (pwmMode) begin
      timerLevel[PIN_A3] = s.pwm[0] ~^ s.output_control_reg[OC_LEVEL_CH_THREE];
      timerLevel[PIN_B3] = s.pwm[0] ^ s.output_control_reg[OC_LEVEL_CH_THREE];
      timerLevel[PIN_A4] = s.pwm[1] ~^ s.output_control_reg[OC_LEVEL_CH_FOUR];
      timerLevel[PIN_XA4] = s.pwm[1] ^ s.output_control_reg[OC_LEVEL_CH_FOUR];
      timerLevel[PIN_B4] = s.pwm[2] ~^ s.output_control_reg[OC_LEVEL_CH_FOUR];
      timerLevel[PIN_XB4] = s.pwm[2] ^ s.output_control_reg[OC_LEVEL_CH_FOUR];
      timerOwns = 6'h3f;
    end else begin
      timerLevel = {1'b0, s.outB[4], 1'b0, s.outA[4], s.outB[3], s.outA[3]};
      timerOwns = {1'b0, ~s.ctrl[4][CTRL_CAP_B], 1'b0, ~s.ctrl[4][CTRL_CAP_A],
                   ~s.ctrl[3][CTRL_CAP_B], ~s.ctrl[3][CTRL_CAP_A]};
    end
    for (int p = 0; p < 6; p++) begin
      if (s.output_master_enable_reg[p] && timerOwns[p]) begin
        n.pinOut[p] = timerLevel[p];
        n.pinOe[p] = 1'b1;
      end else begin
        n.pinOut[p] = portData[p];
        n.pinOe[p] = portDir[p];
      end
    end

    // requests follow the flags and enables that will hold next cycle
    for (int i = 0; i < NUM_CH; i++) begin
      n.irq[3 * i +: 3] = n.flag[i] & n.ier[i];
    end
    n.vec = pickVector(n.irq, {n.prioB, n.prioA});
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s <= '0;
      s.output_master_enable_reg <= RST_OUT_ENABLE;
      s.output_control_reg <= RST_OUT_CONTROL;
      s.vec <= NO_VECTOR;
    end else begin
      s <= n;
    end
  end

  assign regRdata = s.rdata;
  assign pinOut = s.pinOut;
  assign pinOe = s.pinOe;
  assign compareOutA = s.outA;
  assign compareOutB = s.outB;
  assign irqRequest = s.irq;
  assign irqVector = s.vec;

endmodule : tpb_timer
`default_nettype wire

// ==== rtl/tpb_pkg.sv ====
// tpb_pkg: register map, field positions, reset values and codes of the five-channel timer
package tpb_pkg;
  localparam int NUM_CH = 5;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  // per-channel register window: address = {channel, register}
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_COUNTER = 4'h3;
  localparam logic [3:0] REG_COMPARE_A = 4'h4;
  localparam logic [3:0] REG_COMPARE_B = 4'h5;
  localparam logic [3:0] REG_BUFFER_A = 4'h6;
  localparam logic [3:0] REG_BUFFER_B = 4'h7;
  // global registers
  localparam logic [7:0] ADDR_START = 8'h50;
  localparam logic [7:0] ADDR_MODE = 8'h51;
  localparam logic [7:0] ADDR_OUT_ENABLE = 8'h52;
  localparam logic [7:0] ADDR_OUT_CONTROL = 8'h53;
  localparam logic [7:0] ADDR_PRIO_A = 8'h54;
  localparam logic [7:0] ADDR_PRIO_B = 8'h55;
  // control register fields
  localparam int CTRL_PSC_LSB = 0;
  localparam int CTRL_CLR_LSB = 2;
  localparam int CTRL_CAP_A = 4;
  localparam int CTRL_CAP_B = 5;
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_BY_A = 2'h1;
  localparam logic [1:0] CLR_BY_B = 2'h2;
  // status / enable bit positions
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 1;
  localparam int FLAG_WRAP = 2;
  // mode register fields
  localparam int MODE_PHASE = 0;
  localparam int MODE_COMPLEMENTARY = 1;
  localparam int MODE_RESET_SYNC = 2;
  localparam int MODE_BUF_LSB = 3;
  // output control fields
  localparam int OC_EXT_TRIG_DISABLE = 0;
  localparam int OC_LEVEL_CH_THREE = 1;
  localparam int OC_LEVEL_CH_FOUR = 2;
  // pin order of the channel three/four outputs
  localparam int PIN_A3 = 0;
  localparam int PIN_B3 = 1;
  localparam int PIN_A4 = 2;
  localparam int PIN_XA4 = 3;
  localparam int PIN_B4 = 4;
  localparam int PIN_XB4 = 5;
  // reset values and other constants
  localparam logic [5:0] RST_OUT_ENABLE = 6'h3f;
  localparam logic [2:0] RST_OUT_CONTROL = 3'h7;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam logic [3:0] NO_VECTOR = 4'hf;
  localparam int NUM_IRQ = 15;
  localparam int BUF_CH_FIRST = 3;
endpackage : tpb_pkg

// ==== tb/tpb_timer_asserts.sv ====
// tpb_timer_asserts: port-level checks of the timer's bus, request and pin behaviour
`timescale 1ns/1ps
`default_nettype none
module tpb_timer_asserts
  import tpb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [tpb_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tpb_pkg::CNT_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [tpb_pkg::CNT_W-1:0] regRdata,
  // pins and requests
  input wire logic [5:0] portData,
  input wire logic [5:0] portDir,
  input wire logic [5:0] pinOut,
  input wire logic [5:0] pinOe,
  input wire logic [tpb_pkg::NUM_IRQ-1:0] irqRequest,
  input wire logic [3:0] irqVector
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 16'h0)
    else $error("read data present without a read");
  a_unmapped_zero: assert property (regRead && ((regAddr[3] && regAddr < 8'h50) || regAddr > 8'h55)
    |=> regRdata == 16'h0) else $error("unmapped address read nonzero");
  a_unbuffered_zero: assert property (
    regRead && regAddr[7:4] < 4'h3 && regAddr[3:1] == 3'h3 |=> regRdata == 16'h0)
    else $error("buffer register present on an unbuffered channel");
  a_status_width: assert property (
    regRead && regAddr < 8'h50 && (regAddr[3:0] == REG_STATUS || regAddr[3:0] == REG_IRQ_ENABLE)
    |=> regRdata[15:3] == 13'h0) else $error("flag or enable register wider than three bits");
  a_vector_idle: assert property ((irqRequest == 15'h0)[*2] |-> irqVector == NO_VECTOR)
    else $error("vector shown with no request pending");
  a_vector_pending: assert property (
    (irqRequest != 15'h0 && $stable(irqRequest))[*2] |-> irqVector != NO_VECTOR && irqRequest[irqVector])
    else $error("vector does not name a pending request");
  a_pins_release: assert property (
    regWrite && regAddr == ADDR_OUT_ENABLE && regWdata[5:0] == 6'h0
    |-> ##3 pinOe == portDir && pinOut == portData) else $error("pins not handed back to the port");
  a_start_readback: assert property (
    regWrite && regAddr == ADDR_START ##2 regRead && regAddr == ADDR_START
    |=> regRdata[4:0] == $past(regWdata[4:0], 3)) else $error("start bits read back wrong");
  c_request: cover property (irqVector != NO_VECTOR);
  c_enable_read: cover property (regRead && regAddr == ADDR_OUT_ENABLE);
  c_pins_driven: cover property (pinOe == 6'h3f);
endmodule : tpb_timer_asserts
bind tpb_timer tpb_timer_asserts tpb_chk (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .portData(portData), .portDir(portDir), .pinOut(pinOut), .pinOe(pinOe),
  .irqRequest(irqRequest), .irqVector(irqVector));
`default_nettype wire

// ==== tb/tpb_quad_source.sv ====
// tpb_quad_source: quadrature encoder driving the two phase inputs
`timescale 1ns/1ps
`default_nettype none
module tpb_quad_source (
  // clock
  input wire logic clock,
  // encoder outputs
  output logic quadA,
  output logic quadB
);
  // 3 or more keeps phase gap, overlap and pulse width legal; larger values model a slow encoder
  int holdCycles = 3;
  logic [1:0] phase = 2'h0;
  initial begin
    quadA = 1'b0;
    quadB = 1'b0;
  end
  // one edge per call; counting up walks (A,B) through 00, 01, 11, 10
  task step(input bit up);
    phase = up ? phase + 2'h1 : phase - 2'h1;
    @(posedge clock);
    quadA <= phase[1];
    quadB <= phase[1] ^ phase[0];
    repeat (holdCycles) @(posedge clock);
  endtask : step
endmodule : tpb_quad_source
`default_nettype wire

// ==== tb/tpb_timer_test.sv ====
// tpb_timer_test: self-checking bench for the five-channel timer
`timescale 1ns/1ps
`default_nettype none
module tpb_timer_test;
  import tpb_pkg::*;
  typedef struct {logic we; logic [7:0] a; logic [15:0] d; logic [15:0] e;} tpb_row_t;
  localparam logic [5:0] PORT_LEVEL = 6'h2d;
  localparam logic [5:0] PORT_DRIVE = 6'h36;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h0;
  logic [15:0] regWdata = 16'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [4:0] captureInA = 5'h0;
  logic quadA;
  logic quadB;
  logic [15:0] regRdata;
  logic [5:0] pinOut;
  logic [5:0] pinOe;
  logic [14:0] irqRequest;
  logic [3:0] irqVector;
  logic [4:0] cmpOutA;
  logic [15:0] d;
  logic [15:0] p;
  logic [5:0] pins;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  // write flag, address, write data, expected read
  tpb_row_t rows [9] = '{
    '{1'b0, ADDR_OUT_ENABLE, 16'h0, 16'h3f},
    '{1'b0, ADDR_OUT_CONTROL, 16'h0, 16'h7},
    '{1'b0, ADDR_MODE, 16'h0, 16'h0},
    '{1'b0, 8'h22, 16'h0, 16'h0},
    '{1'b1, 8'h06, 16'h1234, 16'h0},
    '{1'b1, 8'h27, 16'h1234, 16'h0},
    '{1'b1, 8'h36, 16'h1234, 16'h1234},
    '{1'b1, 8'h4f, 16'h55aa, 16'h0},
    '{1'b1, ADDR_START, 16'hffe0, 16'h0}};

  tpb_timer DUT (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .quad_input_a(quadA),
    .quad_input_b(quadB), .captureInA(captureInA), .captureInB(5'h0), .portData(PORT_LEVEL),
    .portDir(PORT_DRIVE), .pinOut(pinOut), .pinOe(pinOe), .compareOutA(cmpOutA), .compareOutB(),
    .irqRequest(irqRequest), .irqVector(irqVector));
  tpb_quad_source enc (.clock(clock), .quadA(quadA), .quadB(quadB));

  always #2.5 clock = ~clock;

  task final_report;
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // a hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      final_report();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd

  task rc(input logic [7:0] a, input logic [15:0] v);
    rd(a);
    chk(d, v);
  endtask : rc

  task pulse(input int ch);
    @(posedge clock);
    captureInA[ch] <= 1'b1;
    @(posedge clock);
    captureInA[ch] <= 1'b0;
  endtask : pulse

  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  initial begin
    tick(3);
    sys_rst <= 1'b0;
    tick(2);
    chk(16'(irqVector), 16'(NO_VECTOR));
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    // phase counting on channel two; its slowest prescaler must not matter
    wr(ADDR_MODE, 16'h29);
    wr(8'h20, 16'h3);
    wr(8'h24, 16'h2);
    wr(8'h25, 16'h100);
    wr(8'h21, 16'h1);
    wr(8'h30, 16'h10);
    wr(8'h44, 16'h5);
    wr(8'h46, 16'h9);
    wr(ADDR_START, 16'h1c);
    // two captures ten cycles apart on buffered channel three
    pulse(3);
    tick(8);
    pulse(3);
    tick(2);
    rd(8'h34);
    p = d;
    rd(8'h36);
    chk(p - d, 16'd10);
    rd(8'h32);
    chk(16'(d[FLAG_A]), 16'h1);
    repeat (2) enc.step(1'b1);
    rc(8'h23, 16'h2);
    rc(8'h22, 16'h0);
    enc.step(1'b1);
    rc(8'h23, 16'h3);
    chk(16'(cmpOutA[2]), 16'h1);
    tick(2);
    chk(16'(irqRequest), 16'h40);
    chk(16'(irqVector), 16'h6);
    wr(8'h31, 16'h1);
    tick(3);
    chk(16'(irqVector), 16'h6);
    wr(ADDR_PRIO_B, 16'h3);
    tick(3);
    chk(16'(irqVector), 16'h9);
    wr(ADDR_PRIO_B, 16'h0);
    wr(8'h31, 16'h0);
    // a zero written without a prior read must not clear
    wr(8'h22, 16'h0);
    rc(8'h22, 16'h1);
    wr(8'h22, 16'h0);
    rc(8'h22, 16'h0);
    tick(2);
    chk(16'(irqRequest), 16'h0);
    enc.holdCycles = 6;
    repeat (5) enc.step(1'b0);
    rc(8'h23, 16'hfffe);
    rd(8'h22);
    chk(16'(d[FLAG_WRAP]), 16'h1);
    rc(8'h44, 16'h9);
    // complementary mode with buffered compare B of channel three
    wr(ADDR_START, 16'h0);
    wr(ADDR_MODE, 16'h0);
    wr(ADDR_MODE, 16'h12);
    wr(8'h30, 16'h0);
    wr(8'h33, 16'h2);
    wr(8'h43, 16'h0);
    wr(8'h34, 16'h14);
    wr(8'h35, 16'hc);
    wr(8'h37, 16'h7);
    wr(ADDR_START, 16'h18);
    tick(80);
    rc(8'h35, 16'h7);
    // stopped counters keep the waveform still, so only the level select can move the pins
    wr(ADDR_START, 16'h0);
    tick(3);
    pins = pinOut;
    wr(ADDR_OUT_CONTROL, 16'h1);
    tick(3);
    chk(16'(pinOut), {10'h0, ~pins});
    wr(ADDR_OUT_CONTROL, 16'h0);
    wr(8'h10, 16'h10);
    wr(ADDR_START, 16'h2);
    pulse(1);
    tick(2);
    rc(ADDR_OUT_ENABLE, 16'h0);
    tick(2);
    chk(16'(pinOut), 16'(PORT_LEVEL));
    chk(16'(pinOe), 16'(PORT_DRIVE));
    wr(ADDR_OUT_ENABLE, 16'h0);
    tick(4);
    // reset-synchronized mode moves buffer B3 at compare A of channel three
    wr(ADDR_START, 16'h0);
    wr(ADDR_MODE, 16'h0);
    wr(ADDR_MODE, 16'h14);
    wr(8'h33, 16'h0);
    wr(8'h34, 16'hf);
    wr(8'h37, 16'h9);
    wr(ADDR_START, 16'h8);
    tick(50);
    rc(8'h35, 16'h9);
    final_report();
  end
endmodule : tpb_timer_test
`default_nettype wire
